/* flash_regs_pkg.sv */
package flash_regs_pkg;
    // ==========================================
    // register map (printed offsets are word indices)
    localparam int ADDR_W = 18;
    localparam logic [15:0] CFG_INDEX = 16'hf221;
    localparam logic [15:0] STS_INDEX = 16'hf240;
    localparam logic [15:0] BURST_INDEX = 16'hf230;
    localparam logic [ADDR_W-1:0] CFG_ADDR = {CFG_INDEX, 2'h0};
    localparam logic [ADDR_W-1:0] STS_ADDR = {STS_INDEX, 2'h0};
    localparam logic [ADDR_W-1:0] BURST_ADDR = {BURST_INDEX, 2'h0};
    // ==========================================
    // configuration fields
    localparam int CFG_RM = 15;
    localparam int CFG_BRL = 12;
    localparam int CFG_BL = 9;
    localparam int CFG_ECC = 8;
    localparam int CFG_READY_PIN_POLARITY = 7;
    localparam int CFG_IRQ_PIN_POLARITY = 6;
    localparam int CFG_DRV = 5;
    localparam logic [15:0] CFG_RESET = 16'h40c0;
    localparam logic [2:0] BRL_RESET = 3'h4;
    localparam logic [2:0] BRL_MIN = 3'h3;
    localparam logic [2:0] BL_MAX = 3'h3;
    localparam logic [15:0] CFG_WMASK = 16'hffe0;
    // ==========================================
    // status fields
    localparam int ST_ONGO = 15;
    localparam int ST_LOCK = 14;
    localparam int ST_LOAD = 13;
    localparam int ST_PROG = 12;
    localparam int ST_ERASE = 11;
    localparam int ST_ERROR = 10;
    localparam int ST_SUS = 9;
    localparam int ST_REINIT = 7;
    localparam int ST_ONE_TIME_AREA_LOCKED = 6;
    localparam logic [15:0] STS_RESET = 16'h0000;
    localparam logic [1:0] ECC_UNCORR = 2'h2;
    localparam logic [1:0] ECC_CLEAN = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================
    // types
    typedef enum logic [2:0] {
        OP_LOAD = 3'h0,
        OP_PROG = 3'h1,
        OP_ERASE = 3'h2,
        OP_MBERASE = 3'h3,
        OP_VERIFY = 3'h4,
        OP_RESET = 3'h5
    } op_kind_type;
    typedef enum logic [1:0] {
        ENG_IDLE = 2'h0,
        ENG_BUSY = 2'h1,
        ENG_RESET = 2'h2
    } engine_state_type;
    typedef struct packed {
        logic start;
        op_kind_type kind;
        logic otp;
        logic done;
        logic fail;
        logic locked;
        logic invalid;
        logic suspend;
        logic resume;
    } op_event_type;
    typedef struct packed {
        logic syncRead;
        logic [2:0] latency;
        logic [4:0] burstWords;
        logic wrapBurst;
        logic eccBypass;
    } read_cfg_type;
endpackage

/* status_pin_driver.sv */
`timescale 1ns/1ps
module status_pin_driver (
    input wire logic asserted,
    input wire logic activeHigh,
    input wire logic driveEnable,
    output logic pinOut,
    output logic pinOe
);
    // polarity only matters once the buffer drives the pin
    assign pinOut = activeHigh ? asserted : !asserted;
    assign pinOe = driveEnable;
endmodule

/* flash_config_status_regs.sv */
`timescale 1ns/1ps
// Contract
// - read-mode bit 0 (reset) gives asynchronous reads, 1 synchronous reads.
// - latency field 3..7 cycles, reset 4; codes 000..010 unavailable.
// - burst size continuous, 4, 8, 16 words; higher codes unavailable.
// - fixed-length bursts support wrap-around and linear addressing.
// - correction bypass bit 0 (reset) corrects, 1 bypasses.
// - ready polarity 0 low-for-ready, 1 high-for-ready (reset).
// - interrupt polarity 0 low-for-pending, 1 high-for-pending (reset).
// - master interrupt 0 drives pin 1 at polarity 0, 0 at polarity 1.
// - both pins undriven until drive enable set; enable resets 0.
// - drive enable cleared only by cold reset or writing 0.
// - boot buffer protect bit reads 0, read-only.
// - overall busy reads 1 while any operation runs.
// - locked target sets lock, error and the operation bit.
// - failures and invalid commands set error; invalid sets only error.
// - suspend shows suspend and erase bits, kept through nested operations other than reset and a locked one-time rejection.
// - one-time lock loaded at power-on; when set rejects program/erase.
// - time-out bit fixed 0.
// - operation bits 1 while running, stay 1 with error on failure.
// - status follows per-mode encoding; success clears all flags except a suspend pair kept from a suspended erase.
// - load failure reports correction code 10, load and error set.
// - reset during operation sets that bit, error, reinit busy; load 00; a reset during verify ends with status cleared, no error.
// - one-time block erase leaves status unchanged.
// - interrupt pin follows master interrupt bit through polarity.
module flash_config_status_regs
    import flash_regs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic warmReset,
    input wire logic otpLockIn,
    input wire logic masterIrq,
    input op_event_type opEvent,
    output read_cfg_type readCfg,
    output logic otpReject,
    output logic [1:0] mainCorrection,
    output logic [1:0] spareCorrection,
    output logic irqPinOut,
    output logic irqPinOe,
    output logic rdyPinOut,
    output logic rdyPinOe,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ==========================================
    // register bus write side
    logic [ADDR_W-1:0] awAddr_r;
    logic awHeld_r;
    logic [15:0] wData_r;
    logic [1:0] wStrb_r;
    logic wHeld_r;
    logic doWrite;
    logic [15:0] cfg_r;
    logic wrapBurst_r;
    logic [15:0] sts_r;
    logic otpLocked_r;
    logic otpLoaded_r;

    assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
    assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            awHeld_r <= 1'b0;
            awAddr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wHeld_r <= 1'b0;
            wData_r <= '0;
            wStrb_r <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata[15:0];
            wStrb_r <= s_axi_wstrb[1:0];
        end else if (doWrite) begin
            wHeld_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr_r == CFG_ADDR || awAddr_r == STS_ADDR ||
                            awAddr_r == BURST_ADDR) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================
    // configuration register
    logic [15:0] cfgMerged, cfgWrite;
    logic cfgHit;

    assign cfgHit = doWrite && awAddr_r == CFG_ADDR;
    assign cfgMerged = {wStrb_r[1] ? wData_r[15:8] : cfg_r[15:8],
                        wStrb_r[0] ? wData_r[7:0] : cfg_r[7:0]};
    always_comb begin
        cfgWrite = (cfgMerged & CFG_WMASK) | (cfg_r & ~CFG_WMASK);
        // unavailable latency or burst codes keep the previous setting
        if (cfgMerged[CFG_BRL+:3] < BRL_MIN) begin
            cfgWrite[CFG_BRL+:3] = cfg_r[CFG_BRL+:3];
        end
        if (cfgMerged[CFG_BL+:3] > BL_MAX) begin
            cfgWrite[CFG_BL+:3] = cfg_r[CFG_BL+:3];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cfg_r <= CFG_RESET;
        end else if (cfgHit) begin
            cfg_r <= cfgWrite;
        end else if (warmReset) begin
            // pin polarity and drive enable survive warm reset
            cfg_r[15:CFG_ECC] <= CFG_RESET[15:CFG_ECC];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wrapBurst_r <= 1'b0;
        end else if (doWrite && awAddr_r == BURST_ADDR && wStrb_r[0]) begin
            wrapBurst_r <= wData_r[0];
        end else if (warmReset) begin
            wrapBurst_r <= 1'b0;
        end
    end

    always_comb begin
        readCfg.syncRead = cfg_r[CFG_RM];
        readCfg.latency = cfg_r[CFG_BRL+:3];
        readCfg.eccBypass = cfg_r[CFG_ECC];
        readCfg.wrapBurst = wrapBurst_r;
        unique case (cfg_r[CFG_BL+:2])
            2'h0: readCfg.burstWords = 5'h00;
            2'h1: readCfg.burstWords = 5'h04;
            2'h2: readCfg.burstWords = 5'h08;
            2'h3: readCfg.burstWords = 5'h10;
        endcase
    end

    // ==========================================
    // one-time area lock, caught after cold reset release
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            otpLoaded_r <= 1'b0;
            otpLocked_r <= 1'b0;
        end else if (!otpLoaded_r) begin
            otpLoaded_r <= 1'b1;
            otpLocked_r <= otpLockIn;
        end
    end

    // ==========================================
    // status engine
    engine_state_type eng_r;
    op_kind_type curOp_r;
    logic interrupted_r;
    logic suspended, otpErase;
    logic [15:0] susBits;

    function automatic logic [15:0] opBit(input op_kind_type kind);
        logic [15:0] v;
        v = '0;
        unique case (kind)
            OP_LOAD: v[ST_LOAD] = 1'b1;
            OP_PROG: v[ST_PROG] = 1'b1;
            OP_ERASE, OP_MBERASE: v[ST_ERASE] = 1'b1;
            OP_RESET: v[ST_REINIT] = 1'b1;
            OP_VERIFY: v = '0;
            default: v = '0;
        endcase
        return v;
    endfunction

    assign suspended = sts_r[ST_SUS];
    assign susBits = suspended ? ((16'h1 << ST_SUS) | (16'h1 << ST_ERASE)) : 16'h0;
    assign otpErase = opEvent.otp && opEvent.kind inside {OP_ERASE, OP_MBERASE};
    assign otpReject = opEvent.start && opEvent.otp && otpLocked_r;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            eng_r <= ENG_IDLE;
            curOp_r <= OP_LOAD;
            interrupted_r <= 1'b0;
            sts_r <= STS_RESET;
        end else begin
            unique case (eng_r)
                ENG_IDLE: begin
                    if (opEvent.start && otpErase) begin
                        sts_r <= sts_r;
                    end else if (opEvent.start && opEvent.kind == OP_RESET) begin
                        sts_r <= (16'h1 << ST_ONGO) | (16'h1 << ST_REINIT);
                        interrupted_r <= 1'b0;
                        eng_r <= ENG_RESET;
                    end else if (opEvent.start && opEvent.otp && otpLocked_r) begin
                        sts_r <= opBit(opEvent.kind) | (16'h1 << ST_LOCK) |
                                 (16'h1 << ST_ERROR);
                    end else if (opEvent.start) begin
                        // nested load or program keeps the suspend pair visible
                        sts_r <= (16'h1 << ST_ONGO) | opBit(opEvent.kind) | susBits;
                        curOp_r <= opEvent.kind;
                        eng_r <= ENG_BUSY;
                    end else if (opEvent.resume && suspended) begin
                        sts_r <= (16'h1 << ST_ONGO) | (16'h1 << ST_ERASE);
                        curOp_r <= OP_ERASE;
                        eng_r <= ENG_BUSY;
                    end else if (opEvent.invalid) begin
                        sts_r <= (16'h1 << ST_ERROR) | susBits;
                    end
                end
                ENG_BUSY: begin
                    if (opEvent.start && opEvent.kind == OP_RESET) begin
                        sts_r <= (16'h1 << ST_ONGO) | (16'h1 << ST_REINIT);
                        interrupted_r <= curOp_r != OP_VERIFY;
                        eng_r <= ENG_RESET;
                    end else if (opEvent.suspend && curOp_r inside {OP_ERASE, OP_MBERASE}) begin
                        sts_r <= (16'h1 << ST_SUS) | (16'h1 << ST_ERASE);
                        eng_r <= ENG_IDLE;
                    end else if (opEvent.done && !opEvent.fail && !opEvent.locked) begin
                        sts_r <= susBits;
                        eng_r <= ENG_IDLE;
                    end else if (opEvent.done) begin
                        sts_r <= opBit(curOp_r == OP_VERIFY ? OP_ERASE : curOp_r) |
                                 (16'h1 << ST_ERROR) | susBits |
                                 ({15'h0, opEvent.locked} << ST_LOCK);
                        eng_r <= ENG_IDLE;
                    end else if (opEvent.invalid) begin
                        sts_r[ST_ERROR] <= 1'b1;
                    end
                end
                ENG_RESET: begin
                    if (opEvent.done) begin
                        sts_r <= interrupted_r ? (opBit(curOp_r) | (16'h1 << ST_ERROR) |
                                 (16'h1 << ST_REINIT)) : STS_RESET;
                        eng_r <= ENG_IDLE;
                    end
                end
                default: eng_r <= ENG_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mainCorrection <= ECC_CLEAN;
            spareCorrection <= ECC_CLEAN;
        end else if (eng_r == ENG_BUSY && curOp_r == OP_LOAD && opEvent.done &&
                     opEvent.fail && !opEvent.locked && !opEvent.start) begin
            mainCorrection <= ECC_UNCORR;
            spareCorrection <= ECC_UNCORR;
        end else if (eng_r == ENG_RESET && opEvent.done && interrupted_r &&
                     curOp_r == OP_LOAD) begin
            mainCorrection <= ECC_CLEAN;
            spareCorrection <= ECC_CLEAN;
        end
    end

    // ==========================================
    // register bus read side
    logic [15:0] stsView;
    assign stsView = {sts_r[15:7], otpLocked_r, 6'h00};
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                CFG_ADDR: s_axi_rdata <= {16'h0, cfg_r};
                STS_ADDR: s_axi_rdata <= {16'h0, stsView};
                BURST_ADDR: s_axi_rdata <= {31'h0, wrapBurst_r};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================
    // status pins
    status_pin_driver irqDriver (
        .asserted(masterIrq),
        .activeHigh(cfg_r[CFG_IRQ_PIN_POLARITY]),
        .driveEnable(cfg_r[CFG_DRV]),
        .pinOut(irqPinOut),
        .pinOe(irqPinOe)
    );
    status_pin_driver rdyDriver (
        .asserted(!sts_r[ST_ONGO]),
        .activeHigh(cfg_r[CFG_READY_PIN_POLARITY]),
        .driveEnable(cfg_r[CFG_DRV]),
        .pinOut(rdyPinOut),
        .pinOe(rdyPinOe)
    );

    // ==========================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence busyLoad;
        eng_r == ENG_BUSY && curOp_r == OP_LOAD && opEvent.done && opEvent.fail &&
        !opEvent.locked && !opEvent.start;
    endsequence
    AST_IRQ_PIN: assert property (irqPinOut == (cfg_r[CFG_IRQ_PIN_POLARITY] ~^ masterIrq))
        else $error("irq pin polarity wrong");
    AST_PINS_OFF: assert property (!cfg_r[CFG_DRV] |-> !irqPinOe && !rdyPinOe)
        else $error("status pins driven while disabled");
    AST_DRV_KEEP: assert property (warmReset && !cfgHit |=> $stable(cfg_r[CFG_READY_PIN_POLARITY:CFG_DRV]))
        else $error("warm reset changed pin controls");
    AST_BOOT_ZERO: assert property (cfg_r[0] == 1'b0 && cfg_r[4:1] == 4'h0)
        else $error("reserved config bits set");
    AST_LAT_RANGE: assert property (readCfg.latency >= BRL_MIN)
        else $error("latency code unavailable");
    AST_BURST_RANGE: assert property (cfg_r[CFG_BL+:3] <= BL_MAX)
        else $error("burst code unavailable");
    AST_TO_ZERO: assert property (s_axi_rvalid && s_axi_rresp == RESP_OKAY &&
        $past(s_axi_araddr) == STS_ADDR && $rose(s_axi_rvalid) |-> !s_axi_rdata[0])
        else $error("time-out bit set");
    AST_BUSY_ONGO: assert property (eng_r == ENG_IDLE |-> !sts_r[ST_ONGO])
        else $error("busy shown while idle");
    AST_LOAD_FAIL: assert property (busyLoad |=> mainCorrection == ECC_UNCORR &&
        sts_r[ST_LOAD] && sts_r[ST_ERROR] && !sts_r[ST_ONGO])
        else $error("load failure not reported");
    AST_OTP_ERASE: assert property (eng_r == ENG_IDLE && opEvent.start && otpErase
        |=> $stable(sts_r))
        else $error("one-time erase changed status");
    AST_RESET_INT: assert property (eng_r == ENG_RESET && opEvent.done && interrupted_r
        |=> sts_r[ST_ERROR] && sts_r[ST_REINIT] && eng_r == ENG_IDLE)
        else $error("interrupted operation not flagged");
endmodule

/* axil_host_model.sv */
`timescale 1ns/1ps
module axil_host_model
    import flash_regs_pkg::*;
(
    input wire logic clk_sys,
    output logic [ADDR_W-1:0] s_axi_awaddr = '0,
    output logic s_axi_awvalid = 1'b0,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata = 32'h0,
    output logic [3:0] s_axi_wstrb = 4'h0,
    output logic s_axi_wvalid = 1'b0,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready = 1'b0,
    output logic [ADDR_W-1:0] s_axi_araddr = '0,
    output logic s_axi_arvalid = 1'b0,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready = 1'b0
);
    // ==========================================
    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // ==========================================
    // read: no cycle count assumed, waits for rvalid
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

/* flash_config_status_regs_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %0h got %0h", nm, (e), (g)); end end
module flash_config_status_regs_tb
    import flash_regs_pkg::*;
;
    logic clk_sys, resetn, warmReset, otpLockIn, masterIrq, lastRej;
    op_event_type opEvent;
    read_cfg_type readCfg;
    logic otpReject, irqPinOut, irqPinOe, rdyPinOut, rdyPinOe;
    logic [1:0] mainCorrection, spareCorrection, bresp, rresp, r;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    flash_config_status_regs dut (.clk_sys(clk_sys), .resetn(resetn), .warmReset(warmReset),
        .otpLockIn(otpLockIn), .masterIrq(masterIrq), .opEvent(opEvent), .readCfg(readCfg),
        .otpReject(otpReject), .mainCorrection(mainCorrection),
        .spareCorrection(spareCorrection), .irqPinOut(irqPinOut), .irqPinOe(irqPinOe),
        .rdyPinOut(rdyPinOut), .rdyPinOe(rdyPinOe), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    axil_host_model host (.clk_sys(clk_sys), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // ==========================================
    // helpers
    always #4 clk_sys = ~clk_sys;
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // hang guard, well above the fewer than two hundred cycles the tests need
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic chkReg(input string nm, input logic [ADDR_W-1:0] a, input logic [15:0] e);
        host.rd(a, d, r);
        `CHK(nm, {16'h0000, e}, d)
        `CHK("rresp", RESP_OKAY, r)
    endtask
    task automatic wrReg(input logic [ADDR_W-1:0] a, input logic [15:0] v);
        host.wr(a, v, r);
        `CHK("bresp", RESP_OKAY, r)
    endtask
    task automatic pulse(input logic [10:0] v);
        @(posedge clk_sys);
        opEvent <= op_event_type'(v);
        #1 lastRej = otpReject;
        @(posedge clk_sys);
        opEvent <= '0;
    endtask
    task automatic startOp(input op_kind_type k, input logic o);
        pulse({1'b1, k, o, 6'h00});
    endtask
    task automatic flag(input logic [5:0] f);
        pulse({1'b0, OP_LOAD, 1'b0, f});
    endtask
    task automatic endTest(input string nm);
        $display("test %s done", nm);
    endtask
    // ==========================================
    // main sequence
    initial begin
        clk_sys = 1'b0;
        resetn = 1'b0;
        warmReset = 1'b0;
        otpLockIn = 1'b1;
        masterIrq = 1'b0;
        opEvent = '0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        chkReg("cfg", CFG_ADDR, 16'h40c0);
        `CHK("irqOe", 1'b0, irqPinOe)
        `CHK("rdyOe", 1'b0, rdyPinOe)
        `CHK("latency", 3'h4, readCfg.latency)
        `CHK("burst", 5'h00, readCfg.burstWords)
        endTest("reset");
        wrReg(CFG_ADDR, 16'hb7e0);
        `CHK("sync", 1'b1, readCfg.syncRead)
        `CHK("latency", 3'h3, readCfg.latency)
        `CHK("burst", 5'h10, readCfg.burstWords)
        `CHK("bypass", 1'b1, readCfg.eccBypass)
        wrReg(CFG_ADDR, 16'h89ff);
        chkReg("cfgKeep", CFG_ADDR, 16'hb7e0);
        wrReg(BURST_ADDR, 16'h0001);
        `CHK("wrap", 1'b1, readCfg.wrapBurst)
        wrReg(BURST_ADDR, 16'h0000);
        `CHK("linear", 1'b0, readCfg.wrapBurst)
        endTest("config");
        for (int i = 0; i < 4; i++) begin
            wrReg(CFG_ADDR, 16'hc020 | (16'(i) << 6));
            for (int m = 0; m < 2; m++) begin
                @(posedge clk_sys);
                masterIrq <= m[0];
                @(posedge clk_sys);
                #1;
                `CHK("irqPin", ~(m[0] ^ i[0]), irqPinOut)
                `CHK("rdyPin", i[1], rdyPinOut)
                `CHK("irqOe", 1'b1, irqPinOe)
            end
        end
        wrReg(CFG_ADDR, 16'hc0c0);
        `CHK("oeOff", 1'b0, rdyPinOe)
        endTest("pins");
        wrReg(CFG_ADDR, 16'hb7e0);
        @(posedge clk_sys);
        warmReset <= 1'b1;
        @(posedge clk_sys);
        warmReset <= 1'b0;
        chkReg("cfgWarm", CFG_ADDR, 16'h40e0);
        `CHK("oeWarm", 1'b1, irqPinOe)
        endTest("warm");
        host.wr(18'h00000, 16'h1234, r);
        `CHK("wrUnmapped", RESP_SLVERR, r)
        host.rd(18'h00000, d, r);
        `CHK("rdUnmapped", RESP_SLVERR, r)
        `CHK("rdUnmappedData", 32'h0, d)
        endTest("bus");
        // opcode sequence, status expected with the lock strap high
        startOp(OP_LOAD, 1'b0);
        chkReg("loadBusy", STS_ADDR, 16'ha040);
        `CHK("rdyBusy", 1'b0, rdyPinOut)
        flag(6'h30);
        chkReg("loadFail", STS_ADDR, 16'h2440);
        `CHK("mainEcc", 2'h2, mainCorrection)
        `CHK("spareEcc", 2'h2, spareCorrection)
        startOp(OP_PROG, 1'b0);
        chkReg("progBusy", STS_ADDR, 16'h9040);
        flag(6'h20);
        chkReg("progOk", STS_ADDR, 16'h0040);
        startOp(OP_ERASE, 1'b0);
        flag(6'h28);
        chkReg("eraseLock", STS_ADDR, 16'h4c40);
        flag(6'h04);
        chkReg("invalid", STS_ADDR, 16'h0440);
        startOp(OP_MBERASE, 1'b0);
        chkReg("mbErase", STS_ADDR, 16'h8840);
        flag(6'h02);
        chkReg("suspend", STS_ADDR, 16'h0a40);
        startOp(OP_PROG, 1'b0);
        chkReg("progSusp", STS_ADDR, 16'h9a40);
        flag(6'h30);
        chkReg("progFailSusp", STS_ADDR, 16'h1e40);
        flag(6'h04);
        chkReg("invalidSusp", STS_ADDR, 16'h0e40);
        flag(6'h01);
        flag(6'h20);
        chkReg("eraseOk", STS_ADDR, 16'h0040);
        startOp(OP_VERIFY, 1'b0);
        chkReg("verifyBusy", STS_ADDR, 16'h8040);
        flag(6'h30);
        chkReg("verifyFail", STS_ADDR, 16'h0c40);
        startOp(OP_LOAD, 1'b0);
        startOp(OP_RESET, 1'b0);
        flag(6'h20);
        chkReg("loadReset", STS_ADDR, 16'h24c0);
        `CHK("mainEccReset", 2'h0, mainCorrection)
        `CHK("spareEccReset", 2'h0, spareCorrection)
        startOp(OP_ERASE, 1'b1);
        chkReg("otpErase", STS_ADDR, 16'h24c0);
        startOp(OP_PROG, 1'b1);
        `CHK("otpReject", 1'b1, lastRej)
        chkReg("otpProgLock", STS_ADDR, 16'h5440);
        wrReg(STS_ADDR, 16'hffff);
        chkReg("stsRo", STS_ADDR, 16'h5440);
        endTest("status");
        complete_run();
    end
endmodule
